/* File: fcs_pkg.sv */
// package for the floating-point unit configuration and status register bank
package fcs_pkg;

  // register byte addresses on the apb
  localparam logic [7:0] CFG_ADDR  = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [7:0] EVT_ADDR  = 8'h08;

  // configuration field positions
  localparam int DUAL_FILE_BIT   = 6;
  localparam int OUT_BYPASS_BIT  = 5;
  localparam int PIPE_BYPASS_BIT = 4;
  localparam int FLUSH_ZERO_BIT  = 3;
  localparam int HALF_ORDER_BIT  = 2;
  localparam int RND_HI_BIT      = 1;
  localparam int RND_LO_BIT      = 0;
  localparam int MASK_LO_BIT     = 21;

  // status field positions
  localparam int BELOW_BIT   = 31;
  localparam int GREATER_BIT = 30;
  localparam int EQUAL_BIT   = 29;
  localparam int LARGE_BIT   = 28;
  localparam int BADOP_BIT   = 27;
  localparam int SMALL_BIT   = 26;
  localparam int IMPREC_BIT  = 25;
  localparam int ZDIV_BIT    = 24;
  localparam int PORTA_BIT   = 20;
  localparam int PORTB_BIT   = 19;
  localparam int FAULT_BIT   = 18;
  localparam int IRQEN_BIT   = 12;

  // reset values; exception masks all enabled, output bypass set
  localparam logic [31:0] CFG_RESET  = 32'hffe0_0020;
  localparam logic [31:0] CFG_WMASK  = 32'hffe0_007f;
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

  // rounding modes
  typedef enum logic [1:0] {
    RND_NEAREST = 2'b00,
    RND_ZERO    = 2'b01,
    RND_POS_INF = 2'b10,
    RND_NEG_INF = 2'b11
  } fcs_round_type;

  // controls handed to the datapath
  typedef struct packed {
    logic          dual_file_write;
    logic          output_reg_bypass;
    logic          pipeline_reg_bypass;
    logic          flush_to_zero_select;
    logic          operand_half_order;
    fcs_round_type round_mode;
    logic [10:0]   exc_mask;
  } fcs_ctrl_type;

  // per-operation result events from the datapath
  typedef struct packed {
    logic valid;
    logic is_compare;
    logic below;
    logic greater;
    logic equal;
    logic too_large;
    logic bad_op;
    logic too_small;
    logic imprecise;
    logic zero_divisor;
    logic port_a_special;
    logic port_b_special;
    logic [10:0] exc_src;
  } fcs_event_type;

endpackage

/* File: fcs_regs.sv */
// configuration and status register bank of the floating-point unit
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns

// Behaviour
// - dual_file_write set makes every register write hit both files alike.
// - output_reg_bypass set makes output registers transparent; resets to one.
// - pipeline_reg_bypass set makes pipeline registers transparent; resets to zero.
// - flush_to_zero_select set forces denormal operands and results to zero.
// - operand_half_order zero sends upper half first, one sends lower first.
// - rounding select codes nearest, toward zero, plus infinity, minus infinity.
// - mask bit one enables an exception; enabled exception sets fault flag.
// - in ieee mode denormal operands accepted and denormal results allowed.
// - status register 32 bits, cleared at reset except irq enable in coprocessor.
// - status bit 31 is result sign, or A below B on compare.
// - status bit 30 set when compare finds A greater than B.
// - status bit 29 shows zero result, or A equals B on compare.
// - status bit 28 set on result beyond largest magnitude.
// - status bit 27 set on invalid operation or incoming nan.
// - status bit 26 set on inexact tiny result; flushed in flush mode.
// - status bit 25 set when delivered result is inexact.
// - status bit 24 set on division by zero divisor.
// - status bit 18 is OR of exceptions enabled by masks.
// - status bit 12 enables fault interrupt; resets by operating mode.
// - status bits 20 and 19 flag special value on port A, port B.
module fcs_regs
  import fcs_pkg::*;
#(
  parameter int NUM_EXC = 11
)(
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic                 coproc_mode,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire fcs_pkg::fcs_event_type evt,
  input  wire logic                 rf_wr_en,
  input  wire logic                 rf_wr_sel_b,
  output logic                      rf_wr_a,
  output logic                      rf_wr_b,
  input  wire logic                 op_denormal,
  output logic                      op_flush,
  output fcs_pkg::fcs_ctrl_type     ctrl,
  output logic                      fault_irq
);
  import fcs_pkg::*;

  initial
  begin
    if (NUM_EXC != 11)
      $error("fcs_regs: NUM_EXC must be 11 to fit the mask field");
  end

  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic [31:0] stat_q;
  logic [31:0] stat_d;
  logic        mode_meta_q;
  logic        mode_q;
  logic        irqen_rst_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // address decode, shared by the read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    return a == base;
  endfunction

  wire wr_access  = psel && penable && pwrite;
  wire rd_setup   = psel && !penable && !pwrite;
  wire hit_cfg    = hit(paddr, CFG_ADDR);
  wire hit_stat   = hit(paddr, STAT_ADDR);
  wire hit_evt    = hit(paddr, EVT_ADDR);
  wire mapped     = hit_cfg || hit_stat || hit_evt;
  wire wr_cfg     = wr_access && hit_cfg;
  wire wr_stat    = wr_access && hit_stat;

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // configuration next value; only defined fields are writable
  assign cfg_d = wr_cfg ? ((pwdata & CFG_WMASK) | (cfg_q & ~CFG_WMASK)) : cfg_q;

  // datapath controls
  assign ctrl.dual_file_write      = cfg_q[DUAL_FILE_BIT];
  assign ctrl.output_reg_bypass    = cfg_q[OUT_BYPASS_BIT];
  assign ctrl.pipeline_reg_bypass  = cfg_q[PIPE_BYPASS_BIT];
  assign ctrl.flush_to_zero_select = cfg_q[FLUSH_ZERO_BIT];
  assign ctrl.operand_half_order   = cfg_q[HALF_ORDER_BIT];
  assign ctrl.round_mode = fcs_round_type'({cfg_q[RND_HI_BIT], cfg_q[RND_LO_BIT]});
  assign ctrl.exc_mask   = cfg_q[MASK_LO_BIT +: NUM_EXC];

  // register-file write steering: both files when paired
  assign rf_wr_a = rf_wr_en && (cfg_q[DUAL_FILE_BIT] || !rf_wr_sel_b);
  assign rf_wr_b = rf_wr_en && (cfg_q[DUAL_FILE_BIT] || rf_wr_sel_b);

  // denormals pass in ieee mode, flush to zero otherwise
  assign op_flush = op_denormal && cfg_q[FLUSH_ZERO_BIT];

  // enabled exceptions
  wire enabled_exc = |(evt.exc_src & cfg_q[MASK_LO_BIT +: NUM_EXC]);

  // status next value; hardware events win over a software write
  always_comb
  begin
    stat_d = wr_stat ? pwdata : stat_q;
    stat_d[FAULT_BIT] = stat_q[FAULT_BIT] && !(wr_stat && !pwdata[FAULT_BIT]);
    if (evt.valid)
    begin
      stat_d[BELOW_BIT]   = evt.below;
      stat_d[GREATER_BIT] = evt.is_compare && evt.greater;
      stat_d[EQUAL_BIT]   = evt.equal;
      stat_d[LARGE_BIT]   = evt.too_large;
      stat_d[BADOP_BIT]   = evt.bad_op;
      stat_d[SMALL_BIT]   = evt.too_small;
      stat_d[IMPREC_BIT]  = evt.imprecise;
      stat_d[ZDIV_BIT]    = evt.zero_divisor;
      stat_d[PORTA_BIT]   = evt.port_a_special;
      stat_d[PORTB_BIT]   = evt.port_b_special;
      if (enabled_exc)
        stat_d[FAULT_BIT] = 1'b1;
    end
  end

  // read mux, registered in the setup cycle
  assign prdata_d = !rd_setup ? prdata_q :
                    hit_cfg   ? cfg_q :
                    hit_stat  ? stat_q :
                    hit_evt   ? {31'h0000_0000, mode_q} : ZERO_WORD;

  // interrupt gated by the status enable
  assign fault_irq = stat_q[FAULT_BIT] && stat_q[IRQEN_BIT];
  assign prdata    = prdata_q;

  // configuration register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      cfg_q <= CFG_RESET;
    else
      cfg_q <= cfg_d;
  end

  // mode strap is a pin: two stages, only the second one is read
  // the reset image follows one cycle after reset so the strap is settled
  always_ff @(posedge clk_sys)
  begin
    mode_meta_q <= coproc_mode;
    mode_q      <= mode_meta_q;
    irqen_rst_q <= srst;
  end

  // status register; irq enable loaded from mode after reset
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      stat_q <= STAT_RESET;
    else if (irqen_rst_q)
      stat_q <= stat_d | ({31'h0000_0000, mode_q} << IRQEN_BIT);
    else
      stat_q <= stat_d;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      prdata_q <= ZERO_WORD;
    else
      prdata_q <= prdata_d;
  end

  // checks
  sequence s_fault_event;
    evt.valid && enabled_exc;
  endsequence

  a_fault_sets: assert property (@(posedge clk_sys) disable iff (srst)
    s_fault_event |=> stat_q[FAULT_BIT])
    else $error("fault flag not set by enabled exception");
  a_masked_quiet: assert property (@(posedge clk_sys) disable iff (srst)
    (evt.valid && !enabled_exc && !stat_q[FAULT_BIT]) |=> !stat_q[FAULT_BIT])
    else $error("fault flag set without enabled exception");
  a_dual_write: assert property (@(posedge clk_sys) disable iff (srst)
    (rf_wr_en && cfg_q[DUAL_FILE_BIT]) |-> (rf_wr_a && rf_wr_b))
    else $error("paired write missed a file");
  a_single_write: assert property (@(posedge clk_sys) disable iff (srst)
    (rf_wr_en && !cfg_q[DUAL_FILE_BIT]) |-> (rf_wr_a != rf_wr_b))
    else $error("unpaired write hit wrong files");
  a_bypass_reset: assert property (@(posedge clk_sys)
    $fell(srst) |-> (ctrl.output_reg_bypass && !ctrl.pipeline_reg_bypass))
    else $error("bypass bits wrong after reset");
  a_round_reset: assert property (@(posedge clk_sys)
    $fell(srst) |-> (ctrl.round_mode == RND_NEAREST))
    else $error("rounding not nearest after reset");
  a_flush_zero: assert property (@(posedge clk_sys) disable iff (srst)
    op_flush == (op_denormal && ctrl.flush_to_zero_select))
    else $error("flush does not follow mode");
  a_greater_cmp: assert property (@(posedge clk_sys) disable iff (srst)
    (evt.valid && !evt.is_compare) |=> !stat_q[GREATER_BIT])
    else $error("greater flag set outside compare");
  a_status_clear: assert property (@(posedge clk_sys)
    srst |=> (stat_q == STAT_RESET))
    else $error("status reset image wrong");
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (srst)
    (s_fault_event and (stat_q[IRQEN_BIT] && !wr_stat)) |=> fault_irq)
    else $error("enabled fault did not raise the interrupt");

  // reset release: irq enable taken from the settled strap
  sequence s_release;
    srst ##1 (!srst && !wr_stat);
  endsequence

  a_irqen_load: assert property (@(posedge clk_sys)
    s_release |=>
      (stat_q[IRQEN_BIT] == $past(mode_q)))
    else $error("irq enable does not follow mode after reset");

  a_cfg_reset: assert property (@(posedge clk_sys)
    srst |=>
      (cfg_q == CFG_RESET))
    else $error("configuration reset image wrong");

  // configuration writes land on the defined low fields
  a_cfg_write: assert property (@(posedge clk_sys) disable iff (srst)
    wr_cfg |=>
      (cfg_q[DUAL_FILE_BIT:RND_LO_BIT] == $past(pwdata[DUAL_FILE_BIT:RND_LO_BIT])))
    else $error("configuration write lost");

  a_cfg_hold: assert property (@(posedge clk_sys) disable iff (srst)
    !wr_cfg |=>
      $stable(cfg_q))
    else $error("configuration changed without a write");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (srst)
    1'b1 |->
      ((cfg_q & ~CFG_WMASK) == ZERO_WORD))
    else $error("reserved configuration bits not zero");

  // rounding code mapping
  a_round_up: assert property (@(posedge clk_sys) disable iff (srst)
    (cfg_q[RND_HI_BIT] && !cfg_q[RND_LO_BIT]) |->
      (ctrl.round_mode == RND_POS_INF))
    else $error("round up code wrong");

  a_round_chop: assert property (@(posedge clk_sys) disable iff (srst)
    (!cfg_q[RND_HI_BIT] && cfg_q[RND_LO_BIT]) |->
      (ctrl.round_mode == RND_ZERO))
    else $error("round toward zero code wrong");

  a_flush_off: assert property (@(posedge clk_sys) disable iff (srst)
    !ctrl.flush_to_zero_select |->
      !op_flush)
    else $error("denormal flushed in ieee mode");

  // every operation overwrites its result flags on the next edge
  a_below_track: assert property (@(posedge clk_sys) disable iff (srst)
    evt.valid |=>
      (stat_q[BELOW_BIT] == $past(evt.below)))
    else $error("below flag wrong");

  a_greater_set: assert property (@(posedge clk_sys) disable iff (srst)
    (evt.valid && evt.is_compare) |=>
      (stat_q[GREATER_BIT] == $past(evt.greater)))
    else $error("greater flag wrong on compare");

  a_equal_track: assert property (@(posedge clk_sys) disable iff (srst)
    evt.valid |=>
      (stat_q[EQUAL_BIT] == $past(evt.equal)))
    else $error("equal flag wrong");

  a_large_track: assert property (@(posedge clk_sys) disable iff (srst)
    evt.valid |=>
      (stat_q[LARGE_BIT] == $past(evt.too_large)))
    else $error("overflow flag wrong");

  a_badop_track: assert property (@(posedge clk_sys) disable iff (srst)
    evt.valid |=>
      (stat_q[BADOP_BIT] == $past(evt.bad_op)))
    else $error("invalid flag wrong");

  a_small_track: assert property (@(posedge clk_sys) disable iff (srst)
    evt.valid |=>
      (stat_q[SMALL_BIT] == $past(evt.too_small)))
    else $error("underflow flag wrong");

  a_imprec_track: assert property (@(posedge clk_sys) disable iff (srst)
    evt.valid |=>
      (stat_q[IMPREC_BIT] == $past(evt.imprecise)))
    else $error("inexact flag wrong");

  a_zdiv_track: assert property (@(posedge clk_sys) disable iff (srst)
    evt.valid |=>
      (stat_q[ZDIV_BIT] == $past(evt.zero_divisor)))
    else $error("divide by zero flag wrong");

  a_porta_track: assert property (@(posedge clk_sys) disable iff (srst)
    evt.valid |=>
      (stat_q[PORTA_BIT] == $past(evt.port_a_special)))
    else $error("port a flag wrong");

  a_portb_track: assert property (@(posedge clk_sys) disable iff (srst)
    evt.valid |=>
      (stat_q[PORTB_BIT] == $past(evt.port_b_special)))
    else $error("port b flag wrong");

  // fault bit is sticky until software writes zero to it
  a_fault_sticky: assert property (@(posedge clk_sys) disable iff (srst)
    (stat_q[FAULT_BIT] && !wr_stat) |=>
      stat_q[FAULT_BIT])
    else $error("fault flag dropped by itself");

  a_fault_clear: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_stat && !pwdata[FAULT_BIT] && !(evt.valid && enabled_exc)) |=>
      !stat_q[FAULT_BIT])
    else $error("fault flag not cleared by write");

  a_stat_write: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_stat && !evt.valid) |=>
      (stat_q[BELOW_BIT:PORTB_BIT] == $past(pwdata[BELOW_BIT:PORTB_BIT])))
    else $error("status write lost");

  a_stat_hold: assert property (@(posedge clk_sys) disable iff (srst)
    (!wr_stat && !evt.valid && !irqen_rst_q) |=>
      $stable(stat_q))
    else $error("status changed without a cause");

  // read data latched at setup, shown through the access phase
  sequence s_rd_cfg;
    (psel && !penable && !pwrite && hit_cfg) ##1 (psel && penable);
  endsequence

  sequence s_rd_stat;
    (psel && !penable && !pwrite && hit_stat) ##1 (psel && penable);
  endsequence

  sequence s_rd_mode;
    (psel && !penable && !pwrite && hit_evt) ##1 (psel && penable);
  endsequence

  sequence s_rd_void;
    (psel && !penable && !pwrite && !mapped) ##1 (psel && penable);
  endsequence

  a_read_cfg: assert property (@(posedge clk_sys) disable iff (srst)
    s_rd_cfg |->
      (prdata == $past(cfg_q)))
    else $error("configuration read data wrong");

  a_read_stat: assert property (@(posedge clk_sys) disable iff (srst)
    s_rd_stat |->
      (prdata == $past(stat_q)))
    else $error("status read data wrong");

  a_read_mode: assert property (@(posedge clk_sys) disable iff (srst)
    s_rd_mode |->
      (prdata == {31'h0000_0000, $past(mode_q)}))
    else $error("mode readback wrong");

  a_read_void: assert property (@(posedge clk_sys) disable iff (srst)
    s_rd_void |->
      ((prdata == ZERO_WORD) && pslverr))
    else $error("unmapped read not refused");

  a_void_write: assert property (@(posedge clk_sys) disable iff (srst)
    (psel && penable && pwrite && !mapped) |=>
      ($stable(cfg_q) && $stable(stat_q[FAULT_BIT])))
    else $error("unmapped write changed a register");

  a_prdata_hold: assert property (@(posedge clk_sys) disable iff (srst)
    !rd_setup |=>
      $stable(prdata))
    else $error("read data changed outside a read");

endmodule

/* File: fcs_regs_tb_top.sv */
// self-checking testbench for the fpu configuration and status register bank
`timescale 1ns/1ns
module fcs_regs_tb_top;
  import fcs_pkg::*;
  logic          clk_sys = 1'b0;
  logic          srst = 1'b1;
  logic          coproc_mode = 1'b1;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0000_0000;
  logic [31:0]   prdata;
  logic          pready, pslverr, rf_wr_a, rf_wr_b, op_flush, fault_irq;
  fcs_event_type evt = '0;
  logic          rf_wr_en = 1'b0;
  logic          rf_wr_sel_b = 1'b0;
  logic          op_denormal = 1'b0;
  fcs_ctrl_type  ctrl;
  logic [31:0]   exp_q[$];
  logic [31:0]   lfsr = 32'h0000_0007;
  int            bad_count = 0;
  int            cmp_count = 0;

  fcs_regs fcs_regs_i (.clk_sys(clk_sys), .srst(srst), .coproc_mode(coproc_mode),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt), .rf_wr_en(rf_wr_en),
    .rf_wr_sel_b(rf_wr_sel_b), .rf_wr_a(rf_wr_a), .rf_wr_b(rf_wr_b),
    .op_denormal(op_denormal), .op_flush(op_flush), .ctrl(ctrl), .fault_irq(fault_irq));

  // 250 mhz system clock
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp32(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(logic got, logic exp);
    cmp32({31'h0, got}, {31'h0, exp});
  endtask

  // one apb transfer; the master holds everything until pready is seen high, giving up after 50 edges
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
    cmp_bit(pslverr, err);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp, logic err);
    exp_q.push_back(exp);
    apb(1'b0, a, 32'h0000_0000, err);
  endtask

  // one datapath event, valid high for a single edge
  task automatic fire(fcs_event_type e);
    @(posedge clk_sys);
    evt <= e;
    @(posedge clk_sys);
    evt.valid <= 1'b0;
    #1;
  endtask

  // read monitor: the oldest note is matched against each completed read
  always @(posedge clk_sys)
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp32(prdata, exp_q.pop_front());

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog sized well above the hundred or so cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end

  initial
  begin
    logic [31:0]   w;
    fcs_event_type e;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    rd(CFG_ADDR, CFG_RESET, 1'b0);
    rd(STAT_ADDR, 32'h0000_1000, 1'b0);
    rd(EVT_ADDR, 32'h0000_0001, 1'b0);
    rd(8'h0c, ZERO_WORD, 1'b1);
    $display("test reset done");
    // every rounding code, both file modes, both flush modes
    for (int i = 0; i < 4; i++)
    begin
      lfsr = lfsr_next(lfsr);
      w = {lfsr[31:7], i[1], lfsr[5:4], i[0], lfsr[2], i[1:0]};
      apb(1'b1, CFG_ADDR, w, 1'b0);
      rd(CFG_ADDR, w & CFG_WMASK, 1'b0);
      cmp32({14'h0, ctrl}, {14'h0, w[6:0], w[31:21]});
      rf_wr_en <= 1'b1;
      rf_wr_sel_b <= lfsr[7];
      // denormal only ever offered as a flush request, never raw to multiply
      op_denormal <= lfsr[8];
      @(posedge clk_sys);
      #1;
      cmp_bit(rf_wr_a, w[6] | !lfsr[7]);
      cmp_bit(rf_wr_b, w[6] | lfsr[7]);
      cmp_bit(op_flush, lfsr[8] & w[3]);
    end
    $display("test config done");
    apb(1'b1, CFG_ADDR, CFG_RESET, 1'b0);
    e = '0;
    e.valid = 1'b1;
    e.is_compare = 1'b1;
    e.greater = 1'b1;
    e.zero_divisor = 1'b1;
    e.port_a_special = 1'b1;
    e.exc_src = 11'h001;
    fire(e);
    cmp_bit(fault_irq, 1'b1);
    rd(STAT_ADDR, 32'h4114_1000, 1'b0);
    // non-compare: greater must drop, the fault bit stays sticky
    e = '0;
    e.valid = 1'b1;
    e.greater = 1'b1;
    {e.below, e.equal, e.too_large, e.bad_op, e.too_small, e.imprecise} = 6'h3f;
    e.port_b_special = 1'b1;
    fire(e);
    rd(STAT_ADDR, 32'hbe0c_1000, 1'b0);
    apb(1'b1, STAT_ADDR, 32'h0000_1000, 1'b0);
    rd(STAT_ADDR, 32'h0000_1000, 1'b0);
    cmp_bit(fault_irq, 1'b0);
    // all masks off: exceptions must not reach the fault bit
    apb(1'b1, CFG_ADDR, 32'h0000_0020, 1'b0);
    e = '0;
    e.valid = 1'b1;
    e.exc_src = 11'h7ff;
    fire(e);
    rd(STAT_ADDR, 32'h0000_1000, 1'b0);
    // irq enable cleared: fault bit set but no interrupt
    apb(1'b1, STAT_ADDR, ZERO_WORD, 1'b0);
    apb(1'b1, CFG_ADDR, CFG_RESET, 1'b0);
    e.exc_src = 11'h400;
    fire(e);
    cmp_bit(fault_irq, 1'b0);
    rd(STAT_ADDR, 32'h0004_0000, 1'b0);
    $display("test status done");
    // host-independent mode: a second reset leaves the irq enable clear
    coproc_mode <= 1'b0;
    srst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    rd(STAT_ADDR, STAT_RESET, 1'b0);
    rd(EVT_ADDR, ZERO_WORD, 1'b0);
    rd(CFG_ADDR, CFG_RESET, 1'b0);
    $display("test host mode done");
    repeat (2) @(posedge clk_sys);
    summarize();
  end
endmodule
